// *** src/fpcp_pkg.sv ***
/*
 * Constants, types and timing counts for the front-panel channel programmer.
 * Assumes a single 40 MHz clock and an APB master with 32-bit data.
 */
package fpcp_pkg;
    localparam int NCH = 4;
    localparam int TW = 12;
    // Register byte offsets.
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_CHAN = 8'h08;
    localparam logic [7:0] OFS_THRESHOLD_READOUT_KEY = 8'h0C;
    localparam logic [7:0] OFS_FUNC_A = 8'h10;
    localparam logic [7:0] OFS_FUNC_B = 8'h14;
    // Control register fields and reset value.
    localparam int CTRL_SRC_LSB = 0;
    localparam int CTRL_GATE_BIT = 2;
    localparam logic [2:0] CTRL_RESET = 3'h0;
    localparam logic [1:0] SRC_B = 2'h1;
    localparam logic [1:0] SRC_SEQ = 2'h2;
    // Thresholds in units of 10 mV.
    localparam logic signed [TW-1:0] PRESET_TTL = 12'sh08C;
    localparam logic signed [TW-1:0] PRESET_ECL = -12'sh082;
    localparam logic signed [TW-1:0] ADJ_MAX = 12'sh0FF;
    localparam logic [1:0] SENS_MAX = 2'h2;
    // Level key timing in milliseconds and derived cycle counts.
    localparam int CLK_KHZ = 40000;
    localparam int STEP_SLOW_MS = 400;
    localparam int STEP_FAST_MS = 25;
    localparam int PAUSE_MS = 600;
    localparam int STEP_SLOW_CYC = STEP_SLOW_MS * CLK_KHZ;
    localparam int STEP_FAST_CYC = STEP_FAST_MS * CLK_KHZ;
    localparam int PAUSE_CYC = PAUSE_MS * CLK_KHZ;

    typedef enum logic {MODE_CHAN, MODE_EQN} fpcp_mode_t;

    typedef struct packed {
        logic mode_toggle_key;
        logic [NCH-1:0] channel_key;
        logic display_key;
        logic vdiv_up_key;
        logic vdiv_down_key;
        logic ground_key;
        logic termination_key;
        logic logic_family_key;
        logic threshold_readout_key;
        logic level_up_key;
        logic level_down_key;
        logic probe_offset_key;
        logic clear_key;
        logic and_key;
        logic or_key;
        logic not_key;
        logic edge_key;
        logic func_a_key;
        logic func_b_key;
    } fpcp_keys_t;

    typedef struct packed {
        logic equation_entry_mode;
        logic [NCH-1:0] chan_sel;
        logic [NCH-1:0] display_on;
        logic [NCH-1:0] family_ttl;
        logic [NCH-1:0] grounded;
        logic [NCH-1:0] high_z;
        logic readout_on;
        logic offset_green;
        logic func_b_shown;
    } fpcp_lamps_t;

    typedef struct packed {
        logic [1:0] edge_ch;
        logic edge_en;
        logic [NCH-1:0] pol;
        logic [NCH-1:0] care;
    } fpcp_prod_t;
endpackage

// *** src/fpcp_panel.sv ***
/*
 * Front-panel programmer: key decoding, per-channel settings, threshold
 * readout with held-key stepping, Boolean trigger functions and trigger out.
 * Assumes panel keys and comparators arrive asynchronously, the probe offset
 * sample comes from logic on CLK, and an APB master on the same clock.
 */
// The placing of the registers and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module fpcp_panel
    import fpcp_pkg::*;
#(
    parameter int STEP_SLOW = STEP_SLOW_CYC,
    parameter int STEP_FAST = STEP_FAST_CYC,
    parameter int PAUSE = PAUSE_CYC
) (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic CE,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire fpcp_keys_t KEYS,
    input wire logic [NCH-1:0] COMP,
    input wire logic signed [TW-1:0] OFFSET_SAMPLE,
    output fpcp_lamps_t LAMPS,
    output logic signed [TW-1:0] READOUT,
    output logic [2*NCH-1:0] SENS,
    output logic TRIG_OUT,
    output logic ARMED
);
    localparam int KW = $bits(fpcp_keys_t);

    // Product evaluation: level terms must match, the edge term needs its edge.
    function automatic logic prod_hit(fpcp_prod_t p, logic [NCH-1:0] v,
                                      logic [NCH-1:0] rise, logic [NCH-1:0] fall);
        logic ok;
        ok = |p.care;
        for (int i = 0; i < NCH; i++) begin
            if (p.care[i]) begin
                if (p.edge_en && p.edge_ch == i[1:0]) begin
                    ok = ok & (p.pol[i] ? rise[i] : fall[i]);
                end else begin
                    ok = ok & (v[i] == p.pol[i]);
                end
            end
        end
        return ok;
    endfunction

    // Key and comparator synchronisers, then a previous copy for edges.
    logic [KW-1:0] key_s1_r, key_s2_r, key_prev_r;
    logic [NCH-1:0] cmp_s1_r, cmp_s2_r, cmp_prev_r;
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            key_s1_r <= '0;
            key_s2_r <= '0;
            key_prev_r <= '0;
            cmp_s1_r <= '0;
            cmp_s2_r <= '0;
            cmp_prev_r <= '0;
        end else if (CE) begin
            key_s1_r <= KEYS;
            key_s2_r <= key_s1_r;
            key_prev_r <= key_s2_r;
            cmp_s1_r <= COMP;
            cmp_s2_r <= cmp_s1_r;
            cmp_prev_r <= cmp_s2_r;
        end
    end

    fpcp_keys_t press, held;
    assign held = key_s2_r;
    assign press = key_s2_r & ~key_prev_r;

    // State.
    fpcp_mode_t mode_r;
    logic [1:0] sel_r;
    logic [NCH-1:0] disp_r, ttl_r, gnd_r, hiz_r;
    logic [1:0] sens_r [NCH];
    logic signed [TW-1:0] adj_r [NCH];
    logic signed [TW-1:0] ofs_r [NCH];
    logic readout_on_r;
    logic [2:0] ctrl_r;
    fpcp_prod_t fn_r [2][2];
    logic shown_b_r, prod_ix_r, last_v_r, pend_not_r, pend_edge_r;
    logic [1:0] last_ch_r;

    // Mode gating of key groups; keys of the idle mode are dropped.
    wire in_chan = (mode_r == MODE_CHAN);
    wire in_eqn = (mode_r == MODE_EQN);
    wire lvl_ok = in_chan & readout_on_r;
    wire any_ch = |press.channel_key;
    logic [1:0] ch_ix;
    always_comb begin
        ch_ix = 2'd0;
        for (int i = NCH - 1; i >= 0; i--) begin
            if (press.channel_key[i]) begin
                ch_ix = i[1:0];
            end
        end
    end

    // Mode key toggles between the two modes, one always in force.
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            mode_r <= MODE_CHAN;
        end else if (CE && press.mode_toggle_key) begin
            mode_r <= in_chan ? MODE_EQN : MODE_CHAN;
        end
    end

    // Channel selection only moves in setup mode and survives mode changes.
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            sel_r <= 2'd0;
        end else if (CE && in_chan && any_ch) begin
            sel_r <= ch_ix;
        end
    end

    // Per-channel flag toggles acting on the selected channel, and the single readout toggle.
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            disp_r <= '1;
            ttl_r <= '1;
            gnd_r <= '0;
            hiz_r <= '1;
            readout_on_r <= 1'b0;
        end else if (CE && in_chan) begin
            disp_r[sel_r] <= disp_r[sel_r] ^ press.display_key;
            gnd_r[sel_r] <= gnd_r[sel_r] ^ press.ground_key;
            hiz_r[sel_r] <= hiz_r[sel_r] ^ press.termination_key;
            ttl_r[sel_r] <= ttl_r[sel_r] ^ press.logic_family_key;
            readout_on_r <= readout_on_r ^ press.threshold_readout_key;
        end
    end

    // Sensitivity step: 0 is least sensitive, SENS_MAX most; kept over family changes.
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            for (int i = 0; i < NCH; i++) begin
                sens_r[i] <= 2'd0;
            end
        end else if (CE && in_chan) begin
            if (press.vdiv_up_key && sens_r[sel_r] != SENS_MAX) begin
                sens_r[sel_r] <= sens_r[sel_r] + 2'd1;
            end else if (press.vdiv_down_key && sens_r[sel_r] != 2'd0) begin
                sens_r[sel_r] <= sens_r[sel_r] - 2'd1;
            end
        end
    end

    // Probe offset: acquire a sample, or clear a held one; kept otherwise.
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            for (int i = 0; i < NCH; i++) begin
                ofs_r[i] <= '0;
            end
        end else if (CE && lvl_ok && press.probe_offset_key) begin
            ofs_r[sel_r] <= (ofs_r[sel_r] != 0) ? '0 : OFFSET_SAMPLE;
        end
    end

    // Held level key timing: first push steps at once, then faster, with a
    // pause each time the adjustment comes back to the preset.
    logic [31:0] wait_r, intv_r;
    wire lvl_held = lvl_ok & (held.level_up_key | held.level_down_key);
    wire lvl_push = lvl_ok & (press.level_up_key | press.level_down_key);
    wire step_now = lvl_push | (lvl_held & wait_r == 0);
    wire up_dir = held.level_up_key;
    wire signed [TW-1:0] adj_cur = adj_r[sel_r];
    wire signed [TW-1:0] adj_nxt = up_dir ? adj_cur + 12'sd1 : adj_cur - 12'sd1;
    wire adj_lim = up_dir ? (adj_cur == ADJ_MAX) : (adj_cur == -ADJ_MAX);
    wire [31:0] half_intv = intv_r >> 1;
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            wait_r <= '0;
            intv_r <= '0;
        end else if (CE) begin
            if (!lvl_held) begin
                intv_r <= 32'(STEP_SLOW);
                wait_r <= '0;
            end else if (step_now) begin
                intv_r <= (half_intv < 32'(STEP_FAST)) ? 32'(STEP_FAST) : half_intv;
                wait_r <= (adj_nxt == 0) ? 32'(PAUSE) : intv_r;
            end else begin
                wait_r <= wait_r - 32'd1;
            end
        end
    end

    // Adjustment held per channel, relative to the family preset.
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            for (int i = 0; i < NCH; i++) begin
                adj_r[i] <= '0;
            end
        end else if (CE && step_now && !adj_lim) begin
            adj_r[sel_r] <= adj_nxt;
        end
    end

    // Effective threshold of the selected channel: preset plus adjust plus offset.
    wire signed [TW-1:0] preset_sel = ttl_r[sel_r] ? PRESET_TTL : PRESET_ECL;
    wire signed [TW-1:0] thr_sel = preset_sel + adj_cur + ofs_r[sel_r];

    // Equation entry: channel, NOT and EDGE in any order; AND ends a term, OR
    // moves to the second product, CLEAR wipes only the shown function.
    wire fb = shown_b_r;
    wire pi = prod_ix_r;
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            fn_r <= '{default: '0};
            shown_b_r <= 1'b0;
            prod_ix_r <= 1'b0;
            last_v_r <= 1'b0;
            last_ch_r <= 2'd0;
            pend_not_r <= 1'b0;
            pend_edge_r <= 1'b0;
        end else if (CE && in_eqn) begin
            if (press.func_a_key || press.func_b_key) begin
                shown_b_r <= press.func_b_key;
                prod_ix_r <= 1'b0;
                last_v_r <= 1'b0;
            end else if (press.clear_key) begin
                fn_r[fb] <= '{default: '0};
                prod_ix_r <= 1'b0;
                last_v_r <= 1'b0;
            end else if (press.and_key || press.or_key) begin
                prod_ix_r <= press.or_key ? 1'b1 : pi;
                last_v_r <= 1'b0;
                pend_not_r <= 1'b0;
                pend_edge_r <= 1'b0;
            end else if (any_ch) begin
                fn_r[fb][pi].care[ch_ix] <= 1'b1;
                fn_r[fb][pi].pol[ch_ix] <= ~pend_not_r;
                if (pend_edge_r) begin
                    fn_r[fb][pi].edge_en <= 1'b1;
                    fn_r[fb][pi].edge_ch <= ch_ix;
                end
                last_v_r <= 1'b1;
                last_ch_r <= ch_ix;
                pend_not_r <= 1'b0;
                pend_edge_r <= 1'b0;
            end else if (press.not_key) begin
                if (last_v_r) begin
                    fn_r[fb][pi].pol[last_ch_r] <= ~fn_r[fb][pi].pol[last_ch_r];
                end else begin
                    pend_not_r <= ~pend_not_r;
                end
            end else if (press.edge_key) begin
                if (last_v_r) begin
                    fn_r[fb][pi].edge_en <= !(fn_r[fb][pi].edge_en
                                              && fn_r[fb][pi].edge_ch == last_ch_r);
                    fn_r[fb][pi].edge_ch <= last_ch_r;
                end else begin
                    pend_edge_r <= ~pend_edge_r;
                end
            end
        end
    end

    // Trigger evaluation on grounded-masked comparator levels.
    wire [NCH-1:0] cin = cmp_s2_r & ~gnd_r;
    wire [NCH-1:0] cprev = cmp_prev_r & ~gnd_r;
    wire [NCH-1:0] rise = cin & ~cprev;
    wire [NCH-1:0] fall = ~cin & cprev;
    wire hit_a = prod_hit(fn_r[0][0], cin, rise, fall) | prod_hit(fn_r[0][1], cin, rise, fall);
    wire hit_b = prod_hit(fn_r[1][0], cin, rise, fall) | prod_hit(fn_r[1][1], cin, rise, fall);
    wire [1:0] src = ctrl_r[CTRL_SRC_LSB +: 2];
    wire gate_mode = ctrl_r[CTRL_GATE_BIT];
    wire is_seq = (src == SRC_SEQ);
    wire seq_fire = is_seq & ARMED & hit_b;
    wire trig_nxt = is_seq ? (gate_mode ? (seq_fire | (TRIG_OUT & hit_b)) : seq_fire)
                           : ((src == SRC_B) ? hit_b : hit_a);

    // Arm on A, fire on the next B, then wait for A again.
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            ARMED <= 1'b0;
            TRIG_OUT <= 1'b0;
        end else if (CE) begin
            ARMED <= is_seq & ((ARMED & ~hit_b) | (~ARMED & hit_a));
            TRIG_OUT <= trig_nxt;
        end
    end

    // Panel outputs, registered.
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            LAMPS <= '0;
            READOUT <= '0;
            SENS <= '0;
        end else if (CE) begin
            LAMPS.equation_entry_mode <= in_eqn;
            LAMPS.chan_sel <= NCH'(1) << sel_r;
            LAMPS.display_on <= disp_r;
            LAMPS.family_ttl <= ttl_r;
            LAMPS.grounded <= gnd_r;
            LAMPS.high_z <= hiz_r;
            LAMPS.readout_on <= readout_on_r;
            LAMPS.offset_green <= readout_on_r & (ofs_r[sel_r] != 0);
            LAMPS.func_b_shown <= shown_b_r;
            READOUT <= readout_on_r ? thr_sel : '0;
            for (int i = 0; i < NCH; i++) begin
                SENS[2*i +: 2] <= sens_r[i];
            end
        end
    end

    // APB slave: one wait state, then answer; unmapped addresses give an error.
    wire acc = PSEL & PENABLE & ~PREADY;
    wire hit_ctrl = (PADDR == OFS_CTRL);
    wire hit_stat = (PADDR == OFS_STATUS);
    wire hit_chan = (PADDR == OFS_CHAN);
    wire hit_thr = (PADDR == OFS_THRESHOLD_READOUT_KEY);
    wire hit_fa = (PADDR == OFS_FUNC_A);
    wire hit_fb = (PADDR == OFS_FUNC_B);
    wire mapped = hit_ctrl | hit_stat | hit_chan | hit_thr | hit_fa | hit_fb;
    logic [31:0] chan_word;
    always_comb begin
        chan_word = '0;
        for (int i = 0; i < NCH; i++) begin
            chan_word[8*i +: 6] = {sens_r[i], ttl_r[i], hiz_r[i], gnd_r[i], disp_r[i]};
        end
    end
    wire [31:0] rd_mux =
        hit_ctrl ? {29'h0000_0000, ctrl_r} :
        hit_stat ? {26'h000_0000, TRIG_OUT, ARMED, readout_on_r, sel_r, in_eqn} :
        hit_chan ? chan_word :
        hit_thr ? {20'h0_0000, thr_sel} :
        hit_fa ? {10'h000, fn_r[0][1], fn_r[0][0]} :
        hit_fb ? {10'h000, fn_r[1][1], fn_r[1][0]} : 32'h0000_0000;
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            PREADY <= 1'b0;
            PSLVERR <= 1'b0;
            PRDATA <= '0;
            ctrl_r <= CTRL_RESET;
        end else if (CE) begin
            PREADY <= acc;
            PSLVERR <= acc & ~mapped;
            PRDATA <= (acc & ~PWRITE) ? rd_mux : '0;
            if (acc && PWRITE && hit_ctrl) begin
                ctrl_r <= PWDATA[2:0];
            end
        end
    end
endmodule
`default_nettype wire

// *** verif/fpcp_monitor.sv ***
/*
 * Checker for the front-panel programmer; it sees only the top module ports.
 * Assumes CE stays high while panel keys are pressed and trigger tests run.
 */
`timescale 1ns/1ps
`default_nettype none
module fpcp_monitor
    import fpcp_pkg::*;
(
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic CE,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PREADY,
    input wire logic PSLVERR,
    input wire fpcp_keys_t KEYS,
    input wire fpcp_lamps_t LAMPS,
    input wire logic signed [TW-1:0] READOUT,
    input wire logic [2*NCH-1:0] SENS,
    input wire logic TRIG_OUT,
    input wire logic ARMED
);
    logic [NCH-1:0] key_r;
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_N);
    // Remembers which channel key went down last, so selection can be compared.
    always_ff @(posedge CLK) begin
        if ($rose(|KEYS.channel_key)) begin
            key_r <= KEYS.channel_key;
        end
    end
    // A press is a rising key that is still held one cycle later.
    sequence mode_press;
        $rose(KEYS.mode_toggle_key) ##1 KEYS.mode_toggle_key;
    endsequence
    sequence chan_press;
        $rose(|KEYS.channel_key) && !LAMPS.equation_entry_mode ##1 |KEYS.channel_key;
    endsequence
    mode_toggle_a: assert property (mode_press |-> ##[1:4] $changed(LAMPS.equation_entry_mode))
        else $error("mode key did not toggle the mode");
    chan_select_a: assert property (chan_press |-> ##[1:5] LAMPS.chan_sel == key_r)
        else $error("channel key did not select its channel");
    chan_onehot_a: assert property ($past(RST_N) |-> $onehot(LAMPS.chan_sel))
        else $error("channel selection is not one-hot");
    idle_keys_a: assert property (LAMPS.equation_entry_mode && $past(LAMPS.equation_entry_mode)
        |-> $stable(LAMPS.chan_sel) && $stable(LAMPS.display_on) && $stable(LAMPS.grounded)
        && $stable(LAMPS.high_z) && $stable(LAMPS.family_ttl) && $stable(SENS))
        else $error("channel state changed in equation mode");
    readout_off_a: assert property (!LAMPS.readout_on && !$past(LAMPS.readout_on) |-> READOUT == '0)
        else $error("readout shows a value while switched off");
    sens_range_a: assert property (SENS[1:0] != 2'h3 && SENS[3:2] != 2'h3
        && SENS[5:4] != 2'h3 && SENS[7:6] != 2'h3)
        else $error("sensitivity step out of range");
    apb_answer_a: assert property (PSEL && PENABLE && !PREADY && CE |=> PREADY)
        else $error("access not answered in the next cycle");
    ready_pulse_a: assert property (PREADY && CE |=> !PREADY)
        else $error("ready stood longer than one cycle");
    slverr_ready_a: assert property (PSLVERR |-> PREADY)
        else $error("error flag without ready");
    disarm_fire_a: assert property ($fell(ARMED) |-> TRIG_OUT)
        else $error("armed state cleared without a trigger");
endmodule
bind fpcp_panel fpcp_monitor u_mon (.CLK(CLK), .RST_N(RST_N), .CE(CE), .PSEL(PSEL),
    .PENABLE(PENABLE), .PREADY(PREADY), .PSLVERR(PSLVERR), .KEYS(KEYS), .LAMPS(LAMPS),
    .READOUT(READOUT), .SENS(SENS), .TRIG_OUT(TRIG_OUT), .ARMED(ARMED));
`default_nettype wire

// *** verif/fpcp_panel_model.sv ***
/*
 * Panel pushbutton model: presses the chosen keys for four cycles, then
 * leaves every key up. Assumes requests come right after a clock edge.
 */
`timescale 1ns/1ps
`default_nettype none
module fpcp_panel_model
    import fpcp_pkg::*;
(
    input wire logic clk,
    input wire logic go,
    input wire fpcp_keys_t pick,
    output fpcp_keys_t keys
);
    int cnt = 0;
    initial keys = '0;
    // Released buttons fall back to the unpressed low level before the next press.
    always @(posedge clk) begin
        if (go && cnt == 0) begin
            keys <= pick;
            cnt <= 10;
        end else if (cnt != 0) begin
            cnt <= cnt - 1;
            if (cnt == 7) begin
                keys <= '0;
            end
        end
    end
endmodule
`default_nettype wire

// *** verif/fpcp_panel_tb_top.sv ***
/*
 * Self-checking bench for the front-panel programmer: APB tasks, a reference
 * model of channel state in integers, and trigger scenarios.
 * Assumes the panel model file and the package constants.
 */
`timescale 1ns/1ps
`default_nettype none
module fpcp_panel_tb_top
    import fpcp_pkg::*;
;
    localparam int KMODE = 21, KCH = 17, KDISP = 16, KUP = 15, KDN = 14, KGND = 13;
    localparam int KTERM = 12, KFAM = 11, KRO = 10, KLVL = 9, KOFS = 7, KCLR = 6, KFA = 1;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic go = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata, rdata;
    logic pready, pslverr, rerr, trig_out, armed;
    logic [NCH-1:0] comp = 4'h0;
    logic signed [TW-1:0] ofs_smp = 12'sh000;
    logic signed [TW-1:0] readout;
    logic [2*NCH-1:0] sens;
    fpcp_keys_t keys;
    fpcp_keys_t pick = '0;
    fpcp_lamps_t lamps;
    int mismatches = 0;
    int checks_done = 0;
    int cyc = 0;
    int sel = 0, ro = 0, mode = 0, a, b, hits;
    int disp[4] = '{1, 1, 1, 1};
    int hz[4] = '{1, 1, 1, 1};
    int ttl[4] = '{1, 1, 1, 1};
    int gnd[4] = '{0, 0, 0, 0};
    int sv[4] = '{0, 0, 0, 0};
    int adj[4] = '{0, 0, 0, 0};
    int ofs[4] = '{0, 0, 0, 0};
    int ktab[4] = '{KDISP, KGND, KTERM, KFAM};
    fpcp_panel #(.STEP_SLOW(16), .STEP_FAST(4), .PAUSE(20)) dut (.CLK(clk), .RST_N(rst_n),
        .CE(1'b1), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
        .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .KEYS(keys),
        .COMP(comp), .OFFSET_SAMPLE(ofs_smp), .LAMPS(lamps), .READOUT(readout), .SENS(sens),
        .TRIG_OUT(trig_out), .ARMED(armed));
    fpcp_panel_model pnl (.clk(clk), .go(go), .pick(pick), .keys(keys));
    // The 40 MHz clock and a cycle ceiling that cuts a hang short.
    initial forever #12.5 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            mismatches = mismatches + 1;
            summarize();
        end
    end
    // Reference threshold in 10 mV units: family preset plus adjust plus offset.
    function automatic int thr(input int c);
        return (ttl[c] != 0 ? int'(PRESET_TTL) : int'(PRESET_ECL)) + adj[c] + ofs[c];
    endfunction
    task automatic summarize();
        $display("checks_done %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk_pin(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    // One APB transfer; the request holds until ready is seen at an edge.
    task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 40);
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic chk_reg(input logic [7:0] ad, input logic [31:0] m, input logic [31:0] e,
        input logic ee);
        apb(1'b0, ad, 32'h0000_0000);
        chk_pin("apb_err", {31'h0, ee}, {31'h0, rerr});
        chk_pin("apb_data", e, rdata & m);
    endtask
    // Compares lamps, sensitivity, readout and status registers with the model.
    task automatic check_all();
        logic [31:0] cb;
        logic [3:0] dv, gv, hv, tv;
        for (int i = 0; i < 4; i++) begin
            cb[8*i +: 8] = 8'(disp[i] | gnd[i] << 1 | hz[i] << 2 | ttl[i] << 3 | sv[i] << 4);
            dv[i] = disp[i][0];
            gv[i] = gnd[i][0];
            hv[i] = hz[i][0];
            tv[i] = ttl[i][0];
        end
        chk_pin("sens", 32'({sv[3][1:0], sv[2][1:0], sv[1][1:0], sv[0][1:0]}), 32'(sens));
        chk_pin("chan_sel", 32'(1 << sel), 32'(lamps.chan_sel));
        chk_pin("lamps", 32'({dv, gv, hv, tv, mode[0], ro[0]}), 32'({lamps.display_on,
            lamps.grounded, lamps.high_z, lamps.family_ttl, lamps.equation_entry_mode,
            lamps.readout_on}));
        chk_pin("readout", 32'(ro != 0 ? thr(sel) : 0), 32'(readout));
        if (ro != 0) begin
            chk_pin("green", 32'(ofs[sel] != 0), 32'(lamps.offset_green));
        end
        chk_reg(OFS_CHAN, 32'hFFFF_FFFF, cb, 1'b0);
        chk_reg(OFS_THRESHOLD_READOUT_KEY, 32'h0000_0FFF, 32'(thr(sel)) & 32'h0000_0FFF, 1'b0);
        chk_reg(OFS_STATUS, 32'h0000_000F, 32'(ro << 3 | sel << 1 | mode), 1'b0);
    endtask
    task automatic press(input int k);
        @(posedge clk);
        pick <= fpcp_keys_t'(22'h1 << k);
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        repeat (14) @(posedge clk);
    endtask
    // Main sequence: registers, channel settings, threshold, equations, trigger.
    initial begin
        void'($urandom(25));
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        check_all();
        chk_reg(OFS_CTRL, 32'h0000_0007, 32'(CTRL_RESET), 1'b0);
        chk_reg(8'h20, 32'hFFFF_FFFF, 32'h0000_0000, 1'b1);
        apb(1'b1, OFS_STATUS, 32'hFFFF_FFFF);
        a = $urandom % 4;
        b = (a + 1) % 4;
        sel = a;
        press(KCH + a);
        check_all();
        foreach (ktab[j]) begin
            press(ktab[j]);
            disp[a] ^= (j == 0);
            gnd[a] ^= (j == 1);
            hz[a] ^= (j == 2);
            ttl[a] ^= (j == 3);
            check_all();
        end
        repeat (3) press(KUP);
        sv[a] = 2;
        check_all();
        press(KDN);
        sv[a] = 1;
        ro = 1;
        press(KRO);
        check_all();
        adj[a] = 1;
        press(KLVL);
        check_all();
        sel = b;
        press(KCH + b);
        ofs[b] = 1 + $urandom % 100;
        ofs_smp <= 12'(ofs[b]);
        press(KOFS);
        check_all();
        ttl[b] = 0;
        press(KFAM);
        check_all();
        ro = 0;
        press(KRO);
        sel = a;
        press(KCH + a);
        ro = 1;
        press(KRO);
        check_all();
        sel = b;
        press(KCH + b);
        check_all();
        mode = 1;
        press(KMODE);
        press(KLVL);
        press(KDISP);
        for (int f = 0; f < 2; f++) begin
            press(KFA - f);
            press(KCLR);
            // Channel a is grounded above, so the functions use the two channels after it.
            press(KCH + (b + f) % 4);
            chk_reg(f == 0 ? OFS_FUNC_A : OFS_FUNC_B, 32'h0000_000F, 32'(1 << ((b + f) % 4)),
                1'b0);
        end
        chk_pin("func_b_shown", 32'h0000_0001, 32'(lamps.func_b_shown));
        check_all();
        mode = 0;
        press(KMODE);
        check_all();
        for (int g = 0; g < 2; g++) begin
            apb(1'b1, OFS_CTRL, 32'(SRC_SEQ) << CTRL_SRC_LSB | 32'(g) << CTRL_GATE_BIT);
            comp <= 4'(1 << ((b + 1) % 4));
            repeat (8) @(posedge clk);
            chk_pin("armed_b_first", 32'h0000_0000, 32'(armed));
            comp <= 4'(1 << b);
            repeat (8) @(posedge clk);
            chk_pin("armed_a", 32'h0000_0001, 32'(armed));
            comp <= 4'(1 << ((b + 1) % 4));
            hits = 0;
            repeat (12) begin
                @(posedge clk);
                hits += int'(trig_out);
            end
            chk_pin("trig_shape", 32'h0000_0001, 32'(g != 0 ? hits > 1 : hits == 1));
            chk_pin("rearm_wait", 32'h0000_0000, 32'(armed));
            comp <= 4'h0;
            repeat (8) @(posedge clk);
        end
        // Source B alone follows function B without any arming.
        apb(1'b1, OFS_CTRL, 32'(SRC_B) << CTRL_SRC_LSB);
        comp <= 4'(1 << ((b + 1) % 4));
        repeat (6) @(posedge clk);
        chk_pin("trig_src_b", 32'h0000_0001, 32'(trig_out));
        chk_pin("armed_src_b", 32'h0000_0000, 32'(armed));
        summarize();
    end
endmodule
`default_nettype wire
